// >>> common/nvm_seq_defines.vh
// Constants of the nonvolatile memory command sequencer
`ifndef NVM_SEQ_DEFINES_VH
`define NVM_SEQ_DEFINES_VH
// Register byte addresses on the bus
`define OFS_CMD 8'h00
`define OFS_LOCKS 8'h04
`define OFS_STATUS 8'h08
`define OFS_INTERRUPT_ENABLE_REG 8'h0c
`define OFS_INTFLAG 8'h10
`define OFS_DATA 8'h18
`define OFS_ADDR 8'h20
`define OFS_KEY 8'h24
`define OFS_PBUF 8'h28
// Command codes
`define CMD_NONE 3'h0
`define CMD_PAGE_WRITE 3'h1
`define CMD_PAGE_ERASE 3'h2
`define CMD_ERASE_WRITE 3'h3
`define CMD_BUF_CLEAR 3'h4
`define CMD_CHIP_ERASE 3'h5
`define CMD_EEPROM_WIPE 3'h6
`define CMD_FUSE_WRITE 3'h7
// Unlock key value and its life in bus writes
`define SELF_PROGRAM_KEY 8'h9d
`define KEY_WINDOW 3'h4
// Buffer clear lasts seven cycles
`define BUF_CLEAR_CYCLES 4'h7
// Address bit selecting EEPROM over flash
`define EEPROM_SEL_BIT 15
// Field positions
`define BIT_FLASH_BUSY 0
`define BIT_EEPROM_BUSY 1
`define BIT_WRITE_ERROR 2
`endif

// >>> verilog/nvm_command_sequencer.v
// Command sequencer of the nonvolatile memory controller
`timescale 1ns/1ps
`include "nvm_seq_defines.vh"

// Notes on behaviour
// - Page write programs buffer into addressed page
// - Flash write stalls CPU; EEPROM write does not
// - Buffer auto-cleared after write or erase
// - Page erase needs one written buffer byte
// - Flash erase wipes whole page, halts CPU
// - EEPROM erase touches marked bytes, CPU runs
// - Erase-write erases then programs, buffer cleared
// - Flash erase-write halts CPU; EEPROM does not
// - Buffer clear sets ones, halts seven cycles
// - Chip erase wipes flash, EEPROM unless kept
// - Chip erase ignores boot lock and protect
// - EEPROM wipe sets ones, halts CPU
// - Fuse write only from debug port
// - New fuse applies after reset; readable normally
// - Reset aborts running write or erase
// - Ready flag set when EEPROM becomes free
// - Interrupt while flag and enable both set
// - Clock kept during sleep while writing
// - Ready interrupt wakes from idle only
// - Wake-up clears page buffer to ones
// - Command write needs key within four writes; debug port writes need no key
// - Three-bit command field encodings
// - Buffer store ANDs new data with old
module nvm_command_sequencer #(
    parameter PAGE_BYTES = 32,       // Bytes in one page buffer
    parameter PB_AW = 5,             // Page buffer index width
    parameter OP_CYCLES = 64         // Array operation length in cycles
) (
    input wire clk,
    input wire sys_rst,
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire from_debug_port,      // Access made through program_debug_port
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire eeprom_keep_fuse,     // Fuse level, sampled after reset
    input wire sleep_req,            // System asks for sleep
    input wire sleep_idle,           // Requested sleep is idle mode
    input wire wake_event,           // Wake-up from other sources
    output reg cpu_stall,
    output reg irq,
    output reg wake_out,
    output reg sleep_ok,             // Controller may sleep now
    output reg clk_keep,             // Keep system clock running
    output reg arr_start,            // Start one array operation
    output reg [2:0] arr_op,         // Operation in progress
    output reg [15:0] arr_addr,
    output reg arr_flash_erase_all,
    output reg arr_eeprom_erase_all,
    output reg [7:0] fuse_addr,
    output reg [7:0] fuse_data
);

    // Sequencer states
    localparam S_IDLE = 4'b0001;
    localparam S_ERASE = 4'b0010;
    localparam S_WRITE = 4'b0100;
    localparam S_CLEAR = 4'b1000;

    reg [3:0] state_ff;              // Sequencer state
    reg [2:0] cmd_ff;                // Running command
    reg [15:0] addr_ff;              // Target address
    reg [15:0] data_ff;              // Fuse data register
    reg [1:0] locks_ff;              // Boot lock, app protect
    reg interrupt_enable_reg_ff;                    // Ready interrupt enable
    reg eeprom_ready_flag_ff;        // Sticky ready flag
    reg write_error_ff;              // Refused command seen
    reg [2:0] key_cnt_ff;            // Writes left in unlock window
    reg [15:0] op_cnt_ff;            // Cycles left in array phase
    reg [7:0] pbuf_ff [0:PAGE_BYTES-1]; // Page buffer data
    reg [PAGE_BYTES-1:0] pb_mark_ff; // Bytes written since clear
    reg eeprom_busy_ff;
    reg flash_busy_ff;
    reg sleep_s1_ff, sleep_s2_ff, idle_s1_ff, idle_s2_ff, wake_s1_ff, wake_s2_ff;
    reg asleep_ff;
    reg done_ff;                     // One-cycle pulse at op end
    reg busy_was_ff;
    reg clr_pb_ff;                   // Request a buffer clear
    reg ack_ff;                      // Bus answer given
    wire bus_req = (avs_read | avs_write) & ~ack_ff;
    // A write lands at the edge that sees waitrequest low
    wire wr_hit = avs_write & ack_ff;
    wire target_ee = addr_ff[`EEPROM_SEL_BIT];
    wire op_busy = eeprom_busy_ff | flash_busy_ff;
    wire [7:0] pb_off = avs_address - `OFS_PBUF; // Offset into buffer window
    wire [PB_AW-1:0] pb_idx = pb_off[PB_AW+1:2];
    integer i;

    // Synchronise sleep and wake pins
    always @(posedge clk) begin
        sleep_s1_ff <= sleep_req;
        sleep_s2_ff <= sleep_s1_ff;
        idle_s1_ff <= sleep_idle;
        idle_s2_ff <= idle_s1_ff;
        wake_s1_ff <= wake_event;
        wake_s2_ff <= wake_s1_ff;
    end

    // Bus answers one cycle after request
    always @(posedge clk) begin
        if (sys_rst) begin
            ack_ff <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            ack_ff <= bus_req;
            avs_waitrequest <= ~bus_req;
            if (avs_read & ~ack_ff) begin
                if (avs_address == `OFS_CMD) begin
                    avs_readdata <= {29'h0, cmd_ff};
                end else if (avs_address == `OFS_LOCKS) begin
                    avs_readdata <= {30'h0, locks_ff};
                end else if (avs_address == `OFS_STATUS) begin
                    avs_readdata <= {29'h0, write_error_ff, eeprom_busy_ff, flash_busy_ff};
                end else if (avs_address == `OFS_INTERRUPT_ENABLE_REG) begin
                    avs_readdata <= {31'h0, interrupt_enable_reg_ff};
                end else if (avs_address == `OFS_INTFLAG) begin
                    avs_readdata <= {31'h0, eeprom_ready_flag_ff};
                end else if (avs_address == `OFS_DATA) begin
                    avs_readdata <= {16'h0, data_ff};
                end else if (avs_address == `OFS_ADDR) begin
                    avs_readdata <= {16'h0, addr_ff};
                end else if (avs_address >= `OFS_PBUF) begin
                    avs_readdata <= {24'h0, pbuf_ff[pb_idx]};
                end else begin
                    avs_readdata <= 32'h0;
                end
            end
        end
    end

    // Sleep, clock keep and wake handling
    always @(posedge clk) begin
        if (sys_rst) begin
            asleep_ff <= 1'b0;
            sleep_ok <= 1'b0;
            clk_keep <= 1'b0;
            wake_out <= 1'b0;
            irq <= 1'b0;
            busy_was_ff <= 1'b0;
        end else begin
            busy_was_ff <= eeprom_busy_ff;
            clk_keep <= sleep_s2_ff & op_busy;
            sleep_ok <= sleep_s2_ff & ~op_busy;
            asleep_ff <= sleep_s2_ff;
            irq <= eeprom_ready_flag_ff & interrupt_enable_reg_ff;
            wake_out <= sleep_s2_ff & idle_s2_ff & eeprom_ready_flag_ff & interrupt_enable_reg_ff;
        end
    end

    // Fuse level caught after reset; a new value waits for reset
    reg fuse_taken_ff;
    reg keep_latch_ff;               // Fuse value in force
    always @(posedge clk) begin
        if (sys_rst) begin
            fuse_taken_ff <= 1'b0;
        end else if (!fuse_taken_ff) begin
            fuse_taken_ff <= 1'b1;
        end
    end
    wire keep_fuse_now = fuse_taken_ff ? keep_latch_ff : eeprom_keep_fuse;
    always @(posedge clk) begin
        if (sys_rst) begin
            keep_latch_ff <= 1'b0;
        end else if (!fuse_taken_ff) begin
            keep_latch_ff <= eeprom_keep_fuse;
        end
    end

    // Command, registers, sequencing and page buffer
    always @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= S_IDLE;
            cmd_ff <= `CMD_NONE;
            addr_ff <= 16'h0;
            data_ff <= 16'h0;
            locks_ff <= 2'h0;
            interrupt_enable_reg_ff <= 1'b0;
            eeprom_ready_flag_ff <= 1'b0;
            write_error_ff <= 1'b0;
            key_cnt_ff <= 3'h0;
            op_cnt_ff <= 16'h0;
            pb_mark_ff <= {PAGE_BYTES{1'b0}};
            eeprom_busy_ff <= 1'b0;
            flash_busy_ff <= 1'b0;
            done_ff <= 1'b0;
            clr_pb_ff <= 1'b1;
            cpu_stall <= 1'b0;
            arr_start <= 1'b0;
            arr_op <= `CMD_NONE;
            arr_addr <= 16'h0;
            arr_flash_erase_all <= 1'b0;
            arr_eeprom_erase_all <= 1'b0;
            fuse_addr <= 8'h0;
            fuse_data <= 8'h0;
        end else begin
            arr_start <= 1'b0;
            done_ff <= 1'b0;
            clr_pb_ff <= 1'b0;
            if (wr_hit && key_cnt_ff != 3'h0) begin
                key_cnt_ff <= key_cnt_ff - 3'h1;
            end
            // Wake-up clears the buffer
            if (asleep_ff & (~sleep_s2_ff | wake_s2_ff)) begin
                clr_pb_ff <= 1'b1;
            end
            if (wr_hit) begin
                if (avs_address == `OFS_KEY) begin
                    if (avs_writedata[7:0] == `SELF_PROGRAM_KEY) begin
                        key_cnt_ff <= `KEY_WINDOW;
                    end
                end else if (avs_address == `OFS_CMD) begin
                    if ((key_cnt_ff != 3'h0 || from_debug_port) && state_ff == S_IDLE) begin
                        cmd_ff <= avs_writedata[2:0];
                        arr_addr <= addr_ff;
                        if (avs_writedata[2:0] == `CMD_FUSE_WRITE && !from_debug_port) begin
                            cmd_ff <= `CMD_NONE;
                            write_error_ff <= 1'b1;
                        end else if (avs_writedata[2:0] == `CMD_PAGE_WRITE) begin
                            state_ff <= S_WRITE;
                            arr_start <= 1'b1;
                            arr_op <= `CMD_PAGE_WRITE;
                        end else if (avs_writedata[2:0] == `CMD_PAGE_ERASE ||
                                     avs_writedata[2:0] == `CMD_ERASE_WRITE) begin
                            if (pb_mark_ff != {PAGE_BYTES{1'b0}}) begin
                                state_ff <= S_ERASE;
                                arr_start <= 1'b1;
                                arr_op <= `CMD_PAGE_ERASE;
                            end else begin
                                cmd_ff <= `CMD_NONE;
                                write_error_ff <= 1'b1;
                            end
                        end else if (avs_writedata[2:0] == `CMD_BUF_CLEAR) begin
                            state_ff <= S_CLEAR;
                            op_cnt_ff <= {12'h0, `BUF_CLEAR_CYCLES};
                        end else if (avs_writedata[2:0] == `CMD_CHIP_ERASE) begin
                            state_ff <= S_ERASE;
                            arr_start <= 1'b1;
                            arr_op <= `CMD_CHIP_ERASE;
                            arr_flash_erase_all <= 1'b1;
                            arr_eeprom_erase_all <= ~keep_fuse_now;
                        end else if (avs_writedata[2:0] == `CMD_EEPROM_WIPE) begin
                            state_ff <= S_ERASE;
                            arr_start <= 1'b1;
                            arr_op <= `CMD_EEPROM_WIPE;
                            arr_eeprom_erase_all <= 1'b1;
                        end else if (avs_writedata[2:0] == `CMD_FUSE_WRITE) begin
                            state_ff <= S_WRITE;
                            arr_start <= 1'b1;
                            arr_op <= `CMD_FUSE_WRITE;
                            fuse_addr <= addr_ff[7:0];
                            fuse_data <= data_ff[7:0];
                        end
                    end
                end else if (avs_address == `OFS_LOCKS) begin
                    locks_ff <= locks_ff | avs_writedata[1:0];
                end else if (avs_address == `OFS_INTERRUPT_ENABLE_REG) begin
                    interrupt_enable_reg_ff <= avs_writedata[0];
                end else if (avs_address == `OFS_DATA) begin
                    data_ff <= avs_writedata[15:0];
                end else if (avs_address == `OFS_ADDR) begin
                    addr_ff <= avs_writedata[15:0];
                end else if (avs_address >= `OFS_PBUF && state_ff == S_IDLE) begin
                    pb_mark_ff[pb_idx] <= 1'b1;
                    addr_ff <= {addr_ff[15:PB_AW], pb_idx};
                end
            end
            // Array phase counting and sequencing
            if (state_ff == S_ERASE || state_ff == S_WRITE) begin
                if (arr_start) begin
                    op_cnt_ff <= OP_CYCLES[15:0];
                end else if (op_cnt_ff > 16'h1) begin
                    op_cnt_ff <= op_cnt_ff - 16'h1;
                end else if (state_ff == S_ERASE && cmd_ff == `CMD_ERASE_WRITE) begin
                    state_ff <= S_WRITE;
                    arr_start <= 1'b1;
                    arr_op <= `CMD_PAGE_WRITE;
                end else begin
                    state_ff <= S_IDLE;
                    done_ff <= 1'b1;
                    cmd_ff <= `CMD_NONE;
                    arr_op <= `CMD_NONE;
                    arr_flash_erase_all <= 1'b0;
                    arr_eeprom_erase_all <= 1'b0;
                    clr_pb_ff <= 1'b1;
                end
            end else if (state_ff == S_CLEAR) begin
                if (op_cnt_ff > 16'h1) begin
                    op_cnt_ff <= op_cnt_ff - 16'h1;
                end else begin
                    state_ff <= S_IDLE;
                    cmd_ff <= `CMD_NONE;
                    clr_pb_ff <= 1'b1;
                end
            end
            if (clr_pb_ff) begin
                pb_mark_ff <= {PAGE_BYTES{1'b0}};
            end
            // Busy flags by target
            eeprom_busy_ff <= (state_ff == S_ERASE || state_ff == S_WRITE) && !done_ff
                && (target_ee || cmd_ff == `CMD_EEPROM_WIPE || cmd_ff == `CMD_CHIP_ERASE);
            flash_busy_ff <= (state_ff == S_ERASE || state_ff == S_WRITE) && !done_ff
                && (!target_ee || cmd_ff == `CMD_CHIP_ERASE);
            // Stall flash work, wipes and buffer clear
            cpu_stall <= (state_ff == S_CLEAR)
                || ((state_ff == S_ERASE || state_ff == S_WRITE)
                && (!target_ee || cmd_ff == `CMD_EEPROM_WIPE || cmd_ff == `CMD_CHIP_ERASE));
            // Ready flag: set on busy fall beats a clear
            if (wr_hit && avs_address == `OFS_INTFLAG && avs_writedata[0]) begin
                eeprom_ready_flag_ff <= 1'b0;
            end
            if (busy_was_ff && !eeprom_busy_ff) begin
                eeprom_ready_flag_ff <= 1'b1;
            end
        end
    end

    // Page buffer data: AND on store, ones on clear
    always @(posedge clk) begin
        if (sys_rst || clr_pb_ff) begin
            for (i = 0; i < PAGE_BYTES; i = i + 1) begin
                pbuf_ff[i] <= 8'hff;
            end
        end else if (wr_hit && avs_address >= `OFS_PBUF && state_ff == S_IDLE) begin
            pbuf_ff[pb_idx] <= pbuf_ff[pb_idx] & avs_writedata[7:0];
        end
    end

endmodule // nvm_command_sequencer

// >>> tb/nvm_array_model.sv
// Behavioural model of the memory arrays behind the sequencer
`timescale 1ns/1ps
module nvm_array_model (
    input wire clk,
    input wire arr_start,
    input wire [2:0] arr_op,
    input wire [15:0] arr_addr,
    input wire arr_flash_erase_all,
    input wire arr_eeprom_erase_all,
    output reg [7:0] n_starts,       // Array operations seen so far
    output reg [2:0] last_op,        // Code of the latest operation
    output reg [15:0] last_addr,     // Page of the latest operation
    output reg [1:0] last_all        // Flash and EEPROM wipe flags of it
);
    // Arrays keep no reset of their own, so the log starts clean once
    initial begin
        n_starts = 8'h00;
        last_op = 3'h0;
        last_addr = 16'h0000;
        last_all = 2'h0;
    end
    // Log each started operation with its target and wipe scope
    always @(posedge clk) begin
        if (arr_start) begin
            n_starts <= n_starts + 8'h01;
            last_op <= arr_op;
            last_addr <= arr_addr;
            last_all <= {arr_flash_erase_all, arr_eeprom_erase_all};
        end
    end
endmodule // nvm_array_model

// >>> tb/nvm_seq_checker_sva.sv
// Port assertions for the command sequencer
`timescale 1ns/1ps
`include "nvm_seq_defines.vh"
module nvm_seq_checker #(
    parameter PAGE_BYTES = 32,       // Page size
    parameter PB_AW = 5,             // Buffer index width
    parameter OP_CYCLES = 64         // Array phase length
) (
    input wire clk,
    input wire sys_rst,
    input wire avs_read,
    input wire avs_write,
    input wire avs_waitrequest,
    input wire from_debug_port,
    input wire eeprom_keep_fuse,
    input wire cpu_stall,
    input wire irq,
    input wire wake_out,
    input wire arr_start,
    input wire [2:0] arr_op,
    input wire [15:0] arr_addr,
    input wire arr_flash_erase_all,
    input wire arr_eeprom_erase_all
);
    // One clock domain; reset suspends all checks but a_rst
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Start of a page write, erase or erase-write phase
    wire page_op = arr_start && (arr_op == `CMD_PAGE_WRITE || arr_op == `CMD_PAGE_ERASE
        || arr_op == `CMD_ERASE_WRITE);
    property p_answer; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("request not answered in one cycle");
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");
    property p_pulse; arr_start |=> !arr_start; endproperty
    a_pulse: assert property (p_pulse) else $error("array start longer than one cycle");
    property p_rst;
        disable iff (1'b0) sys_rst |=> avs_waitrequest && !cpu_stall && !arr_start && !irq;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs not idle after reset");
    property p_flash_stall; page_op && !arr_addr[`EEPROM_SEL_BIT] |=> cpu_stall; endproperty
    a_flash_stall: assert property (p_flash_stall) else $error("flash op without stall");
    property p_ee_run; page_op && arr_addr[`EEPROM_SEL_BIT] |=> !cpu_stall; endproperty
    a_ee_run: assert property (p_ee_run) else $error("EEPROM op stalls CPU");
    property p_wipe; arr_start && arr_op == `CMD_EEPROM_WIPE |=> cpu_stall; endproperty
    a_wipe: assert property (p_wipe) else $error("EEPROM wipe without stall");
    property p_chip;
        arr_start && arr_op == `CMD_CHIP_ERASE |-> arr_flash_erase_all
            && arr_eeprom_erase_all == !eeprom_keep_fuse;
    endproperty
    a_chip: assert property (p_chip) else $error("chip erase scope wrong");
    property p_fuse; arr_start && arr_op == `CMD_FUSE_WRITE |-> from_debug_port; endproperty
    a_fuse: assert property (p_fuse) else $error("fuse write not from debug port");
    property p_wake; wake_out |-> irq; endproperty
    a_wake: assert property (p_wake) else $error("wake without ready request");
    // Main scenarios reached
    c_write: cover property (arr_start && arr_op == `CMD_PAGE_WRITE);
    c_chip: cover property (arr_start && arr_op == `CMD_CHIP_ERASE);
    c_wake: cover property (wake_out);
endmodule // nvm_seq_checker

// >>> tb/nvm_command_sequencer_test.sv
// Self-checking testbench of the command sequencer
`timescale 1ns/1ps
`include "nvm_seq_defines.vh"
module nvm_command_sequencer_test;
    reg clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, from_debug_port = 1'b0;
    reg sleep_req = 1'b0, sleep_idle = 1'b0, wake_event = 1'b0, eeprom_keep_fuse = 1'b0;
    reg [7:0] avs_address = 8'h00, base;  // Bus address, start count before a test
    reg [31:0] avs_writedata = 32'h0, q;  // Bus write data, last read data
    wire [31:0] avs_readdata;
    wire avs_waitrequest, cpu_stall, irq, wake_out, sleep_ok, clk_keep, arr_start, fl_all, ee_all;
    wire [2:0] arr_op, last_op;
    wire [15:0] arr_addr, last_addr;
    wire [7:0] fuse_addr, fuse_data, n_starts;
    wire [1:0] last_all;
    integer n_fail = 0, num_checks = 0, cyc = 0, i;
    // Short array phases keep the run brief
    nvm_command_sequencer #(.OP_CYCLES(8)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .from_debug_port(from_debug_port),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .eeprom_keep_fuse(eeprom_keep_fuse), .sleep_req(sleep_req), .sleep_idle(sleep_idle),
        .wake_event(wake_event), .cpu_stall(cpu_stall), .irq(irq), .wake_out(wake_out),
        .sleep_ok(sleep_ok), .clk_keep(clk_keep), .arr_start(arr_start), .arr_op(arr_op),
        .arr_addr(arr_addr), .arr_flash_erase_all(fl_all), .arr_eeprom_erase_all(ee_all),
        .fuse_addr(fuse_addr), .fuse_data(fuse_data));
    nvm_array_model i_arr (.clk(clk), .arr_start(arr_start), .arr_op(arr_op),
        .arr_addr(arr_addr), .arr_flash_erase_all(fl_all), .arr_eeprom_erase_all(ee_all),
        .n_starts(n_starts), .last_op(last_op), .last_addr(last_addr), .last_all(last_all));
    // Clock of 100 ns period
    always #50 clk = ~clk;
    // One bus transfer, held until waitrequest is sampled low
    task xfer(input w, input [7:0] a, input [31:0] d);
        begin
            @(posedge clk);
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= w;
            avs_read <= !w;
            @(posedge clk);
            while (avs_waitrequest !== 1'b0) @(posedge clk);
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d); xfer(1'b1, a, d); endtask
    task rd(input [7:0] a); xfer(1'b0, a, 32'h0); endtask
    // Compare seen against expected and count
    task chk(input [31:0] got, input [31:0] exp, input [8*8-1:0] nm);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("Error %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // Unlock then issue a command
    task cmd(input [2:0] c);
        begin wr(`OFS_KEY, {24'h0, `SELF_PROGRAM_KEY}); wr(`OFS_CMD, {29'h0, c}); end
    endtask
    // Select a page, then store one byte at buffer index 0
    task fill(input [15:0] ad, input [7:0] v);
        begin wr(`OFS_ADDR, {16'h0, ad}); wr(`OFS_PBUF, {24'h0, v}); end
    endtask
    // Poll both busy flags until clear
    task idle; begin rd(`OFS_STATUS); while (q[1:0] !== 2'b00) rd(`OFS_STATUS); end endtask
    task done(input [8*8-1:0] nm); $display("Test %0s done", nm); endtask
    // Counts and verdict, then stop
    task conclude;
        begin
            $display("Checks %0d mismatches %0d", num_checks, n_fail);
            if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            conclude;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`OFS_STATUS); chk(q, 0, "status");
        rd(8'h14); chk(q, 0, "unmapped");
        rd(`OFS_PBUF); chk(q[7:0], 8'hff, "pbuf");
        fill(16'h0040, 8'hf0);
        wr(`OFS_PBUF, 32'h3c);
        rd(`OFS_PBUF); chk(q[7:0], 8'h30, "and");
        done("reset");
        base = n_starts;
        wr(`OFS_CMD, {29'h0, `CMD_PAGE_WRITE});
        wr(`OFS_KEY, {24'h0, `SELF_PROGRAM_KEY});
        for (i = 0; i < 4; i = i + 1) wr(`OFS_DATA, i);
        wr(`OFS_CMD, {29'h0, `CMD_PAGE_WRITE});
        cmd(`CMD_NONE);
        repeat (3) @(posedge clk);
        chk(n_starts, base, "nokey");
        wr(`OFS_KEY, {24'h0, `SELF_PROGRAM_KEY});
        for (i = 0; i < 3; i = i + 1) wr(`OFS_DATA, i);
        wr(`OFS_CMD, {29'h0, `CMD_PAGE_WRITE});
        repeat (2) @(posedge clk);
        chk(cpu_stall, 1, "stall");
        idle;
        chk(n_starts, base + 1, "starts");
        chk(last_op, `CMD_PAGE_WRITE, "op");
        chk(last_addr, 16'h0040, "addr");
        rd(`OFS_PBUF); chk(q[7:0], 8'hff, "pbuf");
        cmd(`CMD_PAGE_ERASE);
        idle;
        chk(n_starts, base + 1, "empty");
        rd(`OFS_STATUS); chk(q[`BIT_WRITE_ERROR], 1, "err");
        fill(16'h0040, 8'h00);
        cmd(`CMD_PAGE_ERASE);
        repeat (2) @(posedge clk);
        chk(cpu_stall, 1, "stall");
        idle;
        chk(last_op, `CMD_PAGE_ERASE, "op");
        done("flash");
        fill(16'h8020, 8'h5a);
        base = n_starts;
        cmd(`CMD_ERASE_WRITE);
        repeat (2) @(posedge clk);
        chk(cpu_stall, 0, "stall");
        idle;
        chk(n_starts, base + 2, "phases");
        chk(last_addr[15], 1, "ee");
        rd(`OFS_PBUF); chk(q[7:0], 8'hff, "pbuf");
        fill(16'h0000, 8'h11);
        cmd(`CMD_BUF_CLEAR);
        i = 0;
        repeat (20) begin @(posedge clk); if (cpu_stall === 1'b1) i = i + 1; end
        chk(i, 7, "clrlen");
        rd(`OFS_PBUF); chk(q[7:0], 8'hff, "pbuf");
        wr(`OFS_LOCKS, 32'h3);
        cmd(`CMD_CHIP_ERASE);
        idle;
        chk(last_op, `CMD_CHIP_ERASE, "op");
        chk(last_all, 2'b11, "all");
        done("erase");
        wr(`OFS_ADDR, 32'h5);
        wr(`OFS_DATA, 32'ha5);
        cmd(`CMD_FUSE_WRITE);
        idle;
        chk(fuse_data, 0, "cpufuse");
        from_debug_port <= 1'b1;
        wr(`OFS_ADDR, 32'h5);
        wr(`OFS_DATA, 32'ha5);
        wr(`OFS_CMD, {29'h0, `CMD_FUSE_WRITE});
        idle;
        from_debug_port <= 1'b0;
        chk(fuse_addr, 8'h05, "fuseadr");
        chk(fuse_data, 8'ha5, "fusedat");
        done("fuse");
        wr(`OFS_INTFLAG, 32'h1);
        wr(`OFS_INTERRUPT_ENABLE_REG, 32'h1);
        cmd(`CMD_EEPROM_WIPE);
        sleep_req <= 1'b1;
        sleep_idle <= 1'b1;
        repeat (4) @(posedge clk);
        chk(cpu_stall, 1, "stall");
        chk(clk_keep, 1, "keep");
        idle;
        repeat (4) @(posedge clk);
        chk(sleep_ok, 1, "sleep");
        chk(irq, 1, "irq");
        chk(wake_out, 1, "wake");
        sleep_idle <= 1'b0;
        repeat (4) @(posedge clk);
        chk(wake_out, 0, "deep");
        wr(`OFS_PBUF, 32'h12);
        rd(`OFS_PBUF); chk(q[7:0], 8'h12, "prewake");
        sleep_req <= 1'b0;
        wake_event <= 1'b1;
        repeat (4) @(posedge clk);
        wake_event <= 1'b0;
        rd(`OFS_PBUF); chk(q[7:0], 8'hff, "wakebuf");
        wr(`OFS_INTFLAG, 32'h0);
        chk(irq, 1, "hold");
        wr(`OFS_INTFLAG, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 0, "clear");
        done("sleep");
        fill(16'h0040, 8'h00);
        cmd(`CMD_PAGE_WRITE);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b1;
        eeprom_keep_fuse <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        chk(cpu_stall, 0, "abort");
        rd(`OFS_STATUS); chk(q, 0, "abort");
        cmd(`CMD_CHIP_ERASE);
        idle;
        chk(last_all, 2'b10, "keep");
        done("abort");
        conclude;
    end
endmodule // nvm_command_sequencer_test
bind nvm_command_sequencer nvm_seq_checker #(.PAGE_BYTES(PAGE_BYTES), .PB_AW(PB_AW),
    .OP_CYCLES(OP_CYCLES)) u_chk (.clk(clk), .sys_rst(sys_rst), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .from_debug_port(from_debug_port),
    .eeprom_keep_fuse(eeprom_keep_fuse), .cpu_stall(cpu_stall), .irq(irq), .wake_out(wake_out),
    .arr_start(arr_start), .arr_op(arr_op), .arr_addr(arr_addr),
    .arr_flash_erase_all(arr_flash_erase_all), .arr_eeprom_erase_all(arr_eeprom_erase_all));
